// file: core/cag_pkg.sv
// Purpose: constants shared by the address generation logic of the core
// Assumes: one clock; memory read data follows a read strobe by a cycle
// Notes:   mode codes are the request encoding on req_mode
package cag_pkg;
    // request modes
    localparam logic [3:0] MODE_TCALL   = 4'h0;
    localparam logic [3:0] MODE_PAIRJMP = 4'h1;
    localparam logic [3:0] MODE_DIRECT  = 4'h2;
    localparam logic [3:0] MODE_SADDR   = 4'h3;
    localparam logic [3:0] MODE_SADDRP  = 4'h4;
    localparam logic [3:0] MODE_SFR     = 4'h5;
    localparam logic [3:0] MODE_REG     = 4'h6;
    localparam logic [3:0] MODE_RPAIR   = 4'h7;
    localparam logic [3:0] MODE_IND     = 4'h8;
    localparam logic [3:0] MODE_BASED   = 4'h9;
    localparam logic [3:0] MODE_PUSH    = 4'ha;
    localparam logic [3:0] MODE_POP     = 4'hb;
    localparam logic [3:0] MODE_PUSHPC  = 4'hc;
    localparam logic [3:0] MODE_POPPC   = 4'hd;
    localparam logic [3:0] MODE_SPLOAD  = 4'he;
    // address map
    localparam logic [15:0] TBL_BASE    = 16'h0040;
    localparam logic [7:0]  SADDR_LOW   = 8'h20;   // first byte outside
    localparam logic [6:0]  SADDR_PAGE  = 7'h7f;   // upper ea bits
    localparam logic [7:0]  SFR_PAGE    = 8'hff;
    localparam logic [15:0] RAM_LO      = 16'hfe80;
    localparam logic [15:0] RAM_HI      = 16'hfeff;
    localparam logic [7:0]  OP_LD_ACC   = 8'h2b;
    // register numbers
    localparam logic [2:0]  REG_A       = 3'h1;
    localparam logic [1:0]  PAIR_ACC    = 2'h0;
    localparam logic [1:0]  PAIR_DATX   = 2'h2;
    localparam logic [1:0]  PAIR_BASE   = 2'h3;
    // reset values
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [15:0] SP_RESET    = 16'hff00;
    localparam logic [7:0]  REG_RESET   = 8'h00;
    // sequencer states, one-hot
    typedef enum logic [9:0] {
        ST_IDLE  = 10'h001,
        ST_TBL_A = 10'h002,
        ST_TBL_B = 10'h004,
        ST_TBL_C = 10'h008,
        ST_PSH_B = 10'h010,
        ST_POP_A = 10'h020,
        ST_POP_B = 10'h040,
        ST_POP_C = 10'h080,
        ST_LD_B  = 10'h100,
        ST_LD_A  = 10'h200
    } cag_state_e;
endpackage : cag_pkg

// file: core/cag_core.sv
// Purpose: branch target and operand address generation for the cpu core
// Assumes: mem_rdata is valid in the cycle after a cycle with mem_rd high
// Notes:   one request at a time, accepted while req_ready is high
`timescale 1ns/1ps
module cag_core (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        req_valid,
    input  wire logic [3:0]  req_mode,
    input  wire logic [7:0]  req_opcode,
    input  wire logic [15:0] req_operand,
    input  wire logic [2:0]  req_reg,
    input  wire logic [15:0] req_pc_seq,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_sel,
    input  wire logic [7:0]  wr_data,
    input  wire logic [7:0]  mem_rdata,
    output logic             req_ready,
    output logic             ea_valid,
    output logic [15:0]      ea,
    output logic             ea_err,
    output logic [15:0]      pc,
    output logic             pc_load,
    output logic [15:0]      sp,
    output logic [15:0]      mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic [7:0]       mem_wdata,
    output logic [7:0]       reg_rdata,
    output logic [15:0]      pair_rdata,
    output logic             done
);
    cag_pkg::cag_state_e state;
    cag_pkg::cag_state_e next_state;
    logic [7:0]  regs [8];
    logic [15:0] pairs [4];
    logic [7:0]  lo_byte;
    logic        pop_to_pc;
    logic [1:0]  pop_pair;

    // byte registers pair up: odd number is the high byte
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pair
            assign pairs[g] = {regs[2*g+1], regs[2*g]};
        end
    endgenerate

    // request decode
    wire         take      = req_valid && req_ready;
    wire [7:0]   imm8      = req_operand[7:0];
    wire [4:0]   tbl_idx   = req_opcode[5:1];
    wire [15:0]  tbl_addr  = cag_pkg::TBL_BASE
                             | {10'h000, tbl_idx, 1'b0};
    wire         sa_sfr    = imm8 < cag_pkg::SADDR_LOW;
    wire         sa_ram    = imm8[7];
    wire [15:0]  sa_ea     = {cag_pkg::SADDR_PAGE, sa_sfr, imm8};
    wire         sa_bad    = !sa_sfr && !sa_ram;
    wire [15:0]  sfr_ea    = {cag_pkg::SFR_PAGE, imm8};
    wire         sfr_bad   = sa_sfr;
    wire [15:0]  hilo      = pairs[cag_pkg::PAIR_BASE];
    wire [15:0]  dext      = pairs[cag_pkg::PAIR_DATX];
    wire [15:0]  ind_ea    = req_reg[0] ? hilo : dext;
    wire         ld_acc    = req_opcode == cag_pkg::OP_LD_ACC;
    wire [15:0]  based_ea  = 16'(hilo + {8'h00, imm8});
    wire [15:0]  sp_dec1   = 16'(sp - 16'h0001);
    wire [15:0]  sp_dec2   = 16'(sp - 16'h0002);
    wire [15:0]  sp_inc2   = 16'(sp + 16'h0002);
    wire [15:0]  psh_data  = (req_mode == cag_pkg::MODE_PUSHPC)
                             ? req_pc_seq : pairs[req_reg[1:0]];
    wire         sp_in_ram = sp >= cag_pkg::RAM_LO
                             && sp <= cag_pkg::RAM_HI;
    wire         is_push   = req_mode == cag_pkg::MODE_PUSH
                             || req_mode == cag_pkg::MODE_PUSHPC;
    wire         is_pop    = req_mode == cag_pkg::MODE_POP
                             || req_mode == cag_pkg::MODE_POPPC;
    wire         ld_start  = req_mode == cag_pkg::MODE_IND && ld_acc;

    // effective address and its fault flag for the accepted request
    logic [15:0] next_ea;
    logic        next_err;
    always_comb begin
        next_ea  = 16'h0000;
        next_err = 1'b0;
        case (req_mode)
            cag_pkg::MODE_DIRECT:  next_ea = req_operand;
            cag_pkg::MODE_SADDR: begin
                next_ea  = sa_ea;
                next_err = sa_bad;
            end
            cag_pkg::MODE_SADDRP: begin
                next_ea  = sa_ea;
                next_err = sa_bad || imm8[0];
            end
            cag_pkg::MODE_SFR: begin
                next_ea  = sfr_ea;
                next_err = sfr_bad;
            end
            cag_pkg::MODE_REG:     next_ea = {13'h0000, req_reg};
            cag_pkg::MODE_RPAIR:   next_ea = {14'h0000, req_reg[1:0]};
            cag_pkg::MODE_IND:
                next_ea = ld_acc ? dext : ind_ea;
            cag_pkg::MODE_BASED:   next_ea = based_ea;
            cag_pkg::MODE_PUSH, cag_pkg::MODE_PUSHPC: begin
                next_ea  = sp_dec2;
                next_err = !sp_in_ram;
            end
            cag_pkg::MODE_POP, cag_pkg::MODE_POPPC: begin
                next_ea  = sp;
                next_err = !sp_in_ram;
            end
            default: begin
                next_ea  = 16'h0000;
                next_err = 1'b0;
            end
        endcase
    end

    // sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            cag_pkg::ST_IDLE: begin
                if (take && req_mode == cag_pkg::MODE_TCALL)
                    next_state = cag_pkg::ST_TBL_A;
                else if (take && is_push)
                    next_state = cag_pkg::ST_PSH_B;
                else if (take && is_pop)
                    next_state = cag_pkg::ST_POP_A;
                else if (take && ld_start)
                    next_state = cag_pkg::ST_LD_A;
            end
            cag_pkg::ST_TBL_A: next_state = cag_pkg::ST_TBL_B;
            cag_pkg::ST_TBL_B: next_state = cag_pkg::ST_TBL_C;
            cag_pkg::ST_POP_A: next_state = cag_pkg::ST_POP_B;
            cag_pkg::ST_POP_B: next_state = cag_pkg::ST_POP_C;
            cag_pkg::ST_LD_A:  next_state = cag_pkg::ST_LD_B; // data lag
            default:           next_state = cag_pkg::ST_IDLE;
        endcase
    end

    // state and handshake
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state     <= cag_pkg::ST_IDLE;
            req_ready <= 1'b1;
        end else begin
            state     <= next_state;
            req_ready <= next_state == cag_pkg::ST_IDLE;
        end
    end

    // address results of every accepted request but table call, pair jump and sp load
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ea_valid   <= 1'b0;
            ea         <= 16'h0000;
            ea_err     <= 1'b0;
            reg_rdata  <= 8'h00;
            pair_rdata <= 16'h0000;
        end else begin
            ea_valid <= take && req_mode != cag_pkg::MODE_TCALL
                        && req_mode != cag_pkg::MODE_PAIRJMP
                        && req_mode != cag_pkg::MODE_SPLOAD;
            if (take) begin
                ea         <= next_ea;
                ea_err     <= next_err;
                reg_rdata  <= regs[req_reg];
                pair_rdata <= pairs[req_reg[1:0]];
            end
        end
    end

    // memory strobes: table reads, stack traffic, accumulator load
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mem_addr  <= 16'h0000;
            mem_rd    <= 1'b0;
            mem_wr    <= 1'b0;
            mem_wdata <= 8'h00;
            lo_byte   <= 8'h00;
        end else begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            if (state == cag_pkg::ST_IDLE && take) begin
                if (req_mode == cag_pkg::MODE_TCALL) begin
                    mem_addr <= tbl_addr;
                    mem_rd   <= 1'b1;
                end else if (is_push) begin
                    mem_addr  <= sp_dec1;
                    mem_wdata <= psh_data[15:8];
                    mem_wr    <= 1'b1;
                    lo_byte   <= psh_data[7:0];
                end else if (is_pop) begin
                    mem_addr <= sp;
                    mem_rd   <= 1'b1;
                end else if (ld_start) begin
                    mem_addr <= dext;
                    mem_rd   <= 1'b1;
                end
            end else if (state == cag_pkg::ST_TBL_A) begin
                mem_addr <= 16'(mem_addr + 16'h0001);
                mem_rd   <= 1'b1;
            end else if (state == cag_pkg::ST_POP_A) begin
                mem_addr <= 16'(mem_addr + 16'h0001);
                mem_rd   <= 1'b1;
            end else if (state == cag_pkg::ST_PSH_B) begin
                mem_addr  <= sp;
                mem_wdata <= lo_byte;
                mem_wr    <= 1'b1;
            end else if (state == cag_pkg::ST_TBL_B
                         || state == cag_pkg::ST_POP_B) begin
                lo_byte <= mem_rdata;
            end
        end
    end

    // program counter and stack pointer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pc        <= cag_pkg::PC_RESET;
            pc_load   <= 1'b0;
            sp        <= cag_pkg::SP_RESET;
            pop_to_pc <= 1'b0;
            pop_pair  <= 2'h0;
        end else begin
            pc_load <= 1'b0;
            if (take && req_mode == cag_pkg::MODE_PAIRJMP) begin
                pc      <= pairs[cag_pkg::PAIR_ACC];
                pc_load <= 1'b1;
            end else if (state == cag_pkg::ST_TBL_C) begin
                pc      <= {mem_rdata, lo_byte};
                pc_load <= 1'b1;
            end else if (state == cag_pkg::ST_POP_C && pop_to_pc) begin
                pc      <= {mem_rdata, lo_byte};
                pc_load <= 1'b1;
            end
            if (take && is_push)
                sp <= sp_dec2;
            else if (take && is_pop)
                sp <= sp_inc2;
            else if (take && req_mode == cag_pkg::MODE_SPLOAD)
                sp <= req_operand;
            if (take && is_pop) begin
                pop_to_pc <= req_mode == cag_pkg::MODE_POPPC;
                pop_pair  <= req_reg[1:0];
            end
        end
    end

    // register file: sequencer writes take priority over the outside port
    wire pop_wr = state == cag_pkg::ST_POP_C && !pop_to_pc;
    wire ld_wr  = state == cag_pkg::ST_LD_B;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < 8; i++)
                regs[i] <= cag_pkg::REG_RESET;
        end else if (pop_wr) begin
            regs[{pop_pair, 1'b1}] <= mem_rdata;
            regs[{pop_pair, 1'b0}] <= lo_byte;
        end else if (ld_wr) begin
            regs[cag_pkg::REG_A] <= mem_rdata;
        end else if (wr_en) begin
            regs[wr_sel] <= wr_data;
        end
    end

    // completion pulse of multi-cycle operations
    always_ff @(posedge clk) begin
        if (!rst_b)
            done <= 1'b0;
        else
            done <= state == cag_pkg::ST_TBL_C || state == cag_pkg::ST_PSH_B
                    || state == cag_pkg::ST_POP_C || ld_wr;
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    tbl_read_addr_a: assert property (
        take && req_mode == cag_pkg::MODE_TCALL |=> mem_rd
        && mem_addr == (16'h0040 | {10'h000, $past(req_opcode[5:1]), 1'b0}))
        else $error("table entry address wrong");
    tbl_pc_load_a: assert property (
        take && req_mode == cag_pkg::MODE_TCALL
        |=> ##2 mem_rd == 1'b0 ##1 pc_load
        && pc[15:8] == $past(mem_rdata) && pc[7:0] == $past(mem_rdata, 2))
        else $error("table call did not load pc");
    pair_jump_a: assert property (
        take && req_mode == cag_pkg::MODE_PAIRJMP
        |=> pc_load && pc == $past({regs[1], regs[0]}))
        else $error("pair jump target wrong");
    direct_ea_a: assert property (
        take && req_mode == cag_pkg::MODE_DIRECT
        |=> ea_valid && ea == $past(req_operand))
        else $error("direct address wrong");
    saddr_window_a: assert property (
        ea_valid && !ea_err && $past(req_mode) == cag_pkg::MODE_SADDR
        |-> ea >= 16'hfe80 && ea <= 16'hff1f)
        else $error("short direct outside window");
    saddr_bit8_a: assert property (
        take && req_mode == cag_pkg::MODE_SADDR
        |=> ea[8] == ($past(req_operand[7:0]) < 8'h20)
        && ea[15:9] == 7'h7f)
        else $error("short direct bit 8 wrong");
    sfr_map_a: assert property (
        take && req_mode == cag_pkg::MODE_SFR
        |=> ea == {8'hff, $past(req_operand[7:0])}
        && ea_err == ($past(req_operand[7:0]) < 8'h20))
        else $error("sfr address wrong");
    based_sum_a: assert property (
        take && req_mode == cag_pkg::MODE_BASED
        |=> ea == 16'($past({regs[7], regs[6]})
                      + {8'h00, $past(req_operand[7:0])}))
        else $error("based address wrong");
    push_order_a: assert property (
        take && is_push
        |=> mem_wr && mem_addr == 16'($past(sp) - 16'h0001)
        ##1 mem_wr && mem_addr == sp && sp == 16'($past(sp, 2) - 16'h0002))
        else $error("push sequence wrong");
    ld_acc_a: assert property (
        take && req_mode == cag_pkg::MODE_IND
        && req_opcode == 8'h2b
        |=> mem_rd && mem_addr == $past({regs[5], regs[4]})
        ##1 ld_wr ##1 regs[1] == $past(mem_rdata) && done)
        else $error("accumulator load wrong");
endmodule : cag_core

// file: testbench/cag_mem_model.sv
// Purpose: byte memory on the far side of the address generator
// Assumes: read data follows a cycle with mem_rd high by one cycle
// Notes:   an idle data line toggles so a stale byte never matches
`timescale 1ns/1ps
module cag_mem_model (
    input  wire logic        clk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [0:65535];

    // address-derived pattern, call table at 40h-7fh included
    initial begin
        mem_rdata = 8'h00;
        for (int a = 0; a < 65536; a++) begin
            mem[a] = a[15:8] ^ a[7:0] ^ 8'h5a;
        end
    end

    // write strobe stores, read answers one cycle later
    always @(posedge clk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (mem_rd) begin
            mem_rdata <= mem[mem_addr];
        end else begin
            mem_rdata <= ~mem_rdata; // released line keeps changing
        end
    end
endmodule : cag_mem_model

// file: testbench/tb.sv
// Purpose: self-checking bench for the address generator
// Assumes: one request at a time, pulses seen at the falling edge
// Notes:   expected values come from the memory pattern and the map
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        req_valid = 1'b0;
    logic [3:0]  req_mode = 4'h0;
    logic [7:0]  req_opcode = 8'h00;
    logic [15:0] req_operand = 16'h0000;
    logic [2:0]  req_reg = 3'h0;
    logic [15:0] req_pc_seq = 16'h2468;
    logic        wr_en = 1'b0;
    logic [2:0]  wr_sel = 3'h0;
    logic [7:0]  wr_data = 8'h00;
    logic [7:0]  mem_rdata, mem_wdata, reg_rdata;
    logic        req_ready, ea_valid, ea_err, pc_load, mem_rd, mem_wr, done;
    logic [15:0] ea, pc, sp, mem_addr, pair_rdata;
    int          mismatches = 0;
    int          checks = 0;

    cag_core i_cag_core (.clk, .rst_b, .req_valid, .req_mode, .req_opcode,
        .req_operand, .req_reg, .req_pc_seq, .wr_en, .wr_sel, .wr_data,
        .mem_rdata, .req_ready, .ea_valid, .ea, .ea_err, .pc, .pc_load,
        .sp, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .reg_rdata,
        .pair_rdata, .done);
    cag_mem_model i_cag_mem_model (.clk, .mem_addr, .mem_rd, .mem_wr,
        .mem_wdata, .mem_rdata);

    always #2 clk = ~clk;

    // pattern byte the memory holds at an address
    function automatic logic [7:0] mv(input logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h5a;
    endfunction : mv

    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk16

    task automatic chk1(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk1

    // one register file write, strobe dropped on the next edge
    task automatic wreg(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_sel <= s;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wreg

    // request held until the edge that samples req_ready high
    task automatic go(input logic [3:0] m, input logic [7:0] o,
                      input logic [15:0] d, input logic [2:0] r);
        int k;
        k = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_mode <= m;
        req_opcode <= o;
        req_operand <= d;
        req_reg <= r;
        do begin
            @(posedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 20);
        if (req_ready !== 1'b1) mismatches++; // never taken
        req_valid <= 1'b0;
    endtask : go

    // count falling edges until ea_valid, pc_load or done pulses
    task automatic wait_pulse(input int w, output logic [15:0] n);
        logic hit;
        n = 16'h0000;
        hit = 1'b0;
        while (!hit && n < 16'h000a) begin
            @(negedge clk);
            n++;
            hit = (w == 0 && ea_valid === 1'b1)
                  || (w == 1 && pc_load === 1'b1)
                  || (w == 2 && done === 1'b1);
        end
        if (!hit) mismatches++; // pulse never came
    endtask : wait_pulse

    // single-cycle address request with its expected result
    task automatic ea_case(input logic [3:0] m, input logic [15:0] d,
                           input logic [2:0] r, input logic [15:0] e,
                           input logic f);
        logic [15:0] n;
        go(m, 8'h00, d, r);
        wait_pulse(0, n);
        chk16(n, 16'h0001);
        chk16(ea, e);
        chk1(ea_err, f);
    endtask : ea_case

    task automatic t_reset;
        @(negedge clk);
        chk1(req_ready, 1'b1);
        chk16(pc, 16'h0000);
        chk16(sp, cag_pkg::SP_RESET);
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs;
        logic [15:0] n;
        for (int i = 0; i < 8; i++) begin
            wreg(3'(i), 8'h10 + 8'(i));
        end
        for (int i = 0; i < 8; i++) begin
            go(cag_pkg::MODE_REG, 8'h00, 16'h0000, 3'(i));
            wait_pulse(0, n);
            chk16(ea, 16'(i));
            chk16({8'h00, reg_rdata}, 16'h0010 + 16'(i));
        end
        for (int p = 0; p < 4; p++) begin
            go(cag_pkg::MODE_RPAIR, 8'h00, 16'h0000, 3'(p));
            wait_pulse(0, n);
            chk16(pair_rdata, 16'h1110 + 16'(p * 16'h0202));
        end
        $display("test regs done");
    endtask : t_regs

    task automatic t_branch;
        logic [15:0] n;
        logic [15:0] a;
        logic [4:0]  idx [3] = '{5'h00, 5'h05, 5'h1f};
        go(cag_pkg::MODE_PAIRJMP, 8'h00, 16'h0000, 3'h0);
        wait_pulse(1, n);
        chk16(n, 16'h0001);
        chk16(pc, 16'h1110);
        foreach (idx[j]) begin
            a = 16'h0040 + {10'h000, idx[j], 1'b0};
            go(cag_pkg::MODE_TCALL, {2'b11, idx[j], 1'b1}, 16'h0000, 3'h0);
            wait_pulse(2, n);
            chk16(n, 16'h0004);
            chk1(pc_load, 1'b1);
            chk16(pc, {mv(a + 16'h0001), mv(a)});
        end
        $display("test branch done");
    endtask : t_branch

    task automatic t_modes;
        ea_case(cag_pkg::MODE_DIRECT, 16'hbeef, 3'h0, 16'hbeef, 1'b0);
        ea_case(cag_pkg::MODE_SADDR, 16'h0080, 3'h0, 16'hfe80, 1'b0);
        ea_case(cag_pkg::MODE_SADDR, 16'h00ff, 3'h0, 16'hfeff, 1'b0);
        ea_case(cag_pkg::MODE_SADDR, 16'h0000, 3'h0, 16'hff00, 1'b0);
        ea_case(cag_pkg::MODE_SADDR, 16'h001f, 3'h0, 16'hff1f, 1'b0);
        ea_case(cag_pkg::MODE_SADDR, 16'h3390, 3'h0, 16'hfe90, 1'b0);
        ea_case(cag_pkg::MODE_SADDR, 16'h0020, 3'h0, 16'hfe20, 1'b1);
        ea_case(cag_pkg::MODE_SADDRP, 16'h0090, 3'h0, 16'hfe90, 1'b0);
        ea_case(cag_pkg::MODE_SADDRP, 16'h0091, 3'h0, 16'hfe91, 1'b1);
        ea_case(cag_pkg::MODE_SFR, 16'h0020, 3'h0, 16'hff20, 1'b0);
        ea_case(cag_pkg::MODE_SFR, 16'h00ff, 3'h0, 16'hffff, 1'b0);
        ea_case(cag_pkg::MODE_SFR, 16'h0010, 3'h0, 16'hff10, 1'b1);
        ea_case(cag_pkg::MODE_IND, 16'h0000, 3'h0, 16'h1514, 1'b0);
        ea_case(cag_pkg::MODE_IND, 16'h0000, 3'h1, 16'h1716, 1'b0);
        $display("test modes done");
    endtask : t_modes

    task automatic t_stack;
        logic [15:0] n;
        go(cag_pkg::MODE_IND, cag_pkg::OP_LD_ACC, 16'h0000, 3'h0);
        wait_pulse(2, n);
        chk16(n, 16'h0003);
        go(cag_pkg::MODE_REG, 8'h00, 16'h0000, 3'h1);
        wait_pulse(0, n);
        chk16({8'h00, reg_rdata}, {8'h00, mv(16'h1514)});
        go(cag_pkg::MODE_SPLOAD, 8'h00, 16'hfee0, 3'h0);
        @(negedge clk);
        chk16(sp, 16'hfee0);
        go(cag_pkg::MODE_PUSH, 8'h00, 16'h0000, 3'h2);
        wait_pulse(2, n);
        chk16(n, 16'h0002);
        chk16(sp, 16'hfede);
        @(negedge clk); // low byte lands one edge after done
        chk16({8'h00, i_cag_mem_model.mem[16'hfedf]}, 16'h0015);
        chk16({8'h00, i_cag_mem_model.mem[16'hfede]}, 16'h0014);
        go(cag_pkg::MODE_POP, 8'h00, 16'h0000, 3'h1);
        wait_pulse(2, n);
        chk16(n, 16'h0004);
        chk16(sp, 16'hfee0);
        go(cag_pkg::MODE_RPAIR, 8'h00, 16'h0000, 3'h1);
        wait_pulse(0, n);
        chk16(pair_rdata, 16'h1514);
        go(cag_pkg::MODE_PUSHPC, 8'h00, 16'h0000, 3'h0);
        wait_pulse(2, n);
        go(cag_pkg::MODE_POPPC, 8'h00, 16'h0000, 3'h0);
        wait_pulse(2, n);
        chk16(pc, 16'h2468);
        chk16(sp, 16'hfee0);
        $display("test stack done");
    endtask : t_stack

    task automatic t_based;
        wreg(3'h6, 8'hff);
        wreg(3'h7, 8'hff);
        ea_case(cag_pkg::MODE_BASED, 16'h0010, 3'h0, 16'h000f, 1'b0);
        ea_case(cag_pkg::MODE_BASED, 16'h0080, 3'h0, 16'h007f, 1'b0);
        $display("test based done");
    endtask : t_based

    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // main sequence after eight cycles of reset
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_regs;
        t_branch;
        t_modes;
        t_stack;
        t_based;
        end_of_test;
    end

    // watchdog well beyond the 130 or so cycles the tests need
    initial begin
        #40000;
        mismatches++;
        $display("watchdog expired");
        end_of_test;
    end
endmodule : tb
